// ===== verilog/txdrv_pkg.sv
package txdrv_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_DRIVE_MODE = 8'h28;
    localparam logic [7:0] IDX_CARRIER_AMP = 8'h29;
    localparam logic [7:0] IDX_TX_CONTROL = 8'h2A;
    localparam logic [7:0] IDX_LOAD_OVERSHOOT = 8'h2B;
    localparam logic [7:0] IDX_CRC_CONFIG = 8'h2C;
    // Writable bit masks; reserved bits read as zero.
    localparam logic [7:0] MASK_DRIVE_MODE = 8'hCF;
    localparam logic [7:0] MASK_CARRIER_AMP = 8'hDF;
    localparam logic [7:0] MASK_CRC_CONFIG = 8'h7F;
    localparam logic [7:0] RST_REG = 8'h00;
    // Field positions.
    localparam int B_INV2 = 7;
    localparam int B_INV1 = 6;
    localparam int B_TRANSMITTER_OUTPUTS_ENABLE = 3;
    localparam int B_CWMAX = 3;
    localparam int B_MODINV = 2;
    localparam int B_CRCINV = 1;
    localparam int B_CRCEN = 0;
    // Output drive style codes.
    localparam logic [2:0] STYLE_PUSH_PULL = 3'h0;
    localparam logic [2:0] STYLE_OPEN_DRAIN = 3'h1;
    localparam logic [2:0] STYLE_HIGH_Z = 3'h2;
    localparam logic [2:0] STYLE_FIX_LOW = 3'h5;
    localparam logic [2:0] STYLE_FIX_HIGH = 3'h6;
    // Modulation source codes.
    localparam logic [1:0] MOD_NONE = 2'h0;
    localparam logic [1:0] MOD_ENVELOPE = 2'h1;
    localparam logic [1:0] MOD_SERIAL = 2'h2;
    // Carrier reduction below the transmitter supply, in millivolts.
    localparam logic [10:0] CW_RED_0 = 11'h064;
    localparam logic [10:0] CW_RED_1 = 11'h0FA;
    localparam logic [10:0] CW_RED_2 = 11'h1F4;
    localparam logic [10:0] CW_RED_3 = 11'h3E8;
    localparam logic [10:0] CW_RED_NONE = 11'h000;
    // CRC types, widths and reflected polynomials (shifted LSB first).
    localparam logic [1:0] CRC_T5 = 2'h0;
    localparam logic [1:0] CRC_T8 = 2'h1;
    localparam logic [1:0] CRC_T16 = 2'h2;
    localparam logic [4:0] CRC_W5 = 5'h05;
    localparam logic [4:0] CRC_W8 = 5'h08;
    localparam logic [4:0] CRC_W16 = 5'h10;
    localparam logic [15:0] POLY5 = 16'h0012;
    localparam logic [15:0] POLY8 = 16'h00B8;
    localparam logic [15:0] POLY16 = 16'h8408;
    localparam logic [15:0] MASK5 = 16'h001F;
    localparam logic [15:0] MASK8 = 16'h00FF;
    localparam logic [15:0] MASK16 = 16'hFFFF;
    // Preset codes and values.
    localparam logic [2:0] PRE_C0 = 3'h0;
    localparam logic [2:0] PRE_C1 = 3'h1;
    localparam logic [2:0] PRE_C2 = 3'h2;
    localparam logic [2:0] PRE_C3 = 3'h3;
    localparam logic [2:0] PRE_USER = 3'h6;
    localparam logic [2:0] PRE_C7 = 3'h7;
    localparam logic [15:0] P16_1 = 16'h6363;
    localparam logic [15:0] P16_2 = 16'hA671;
    localparam logic [15:0] P16_3 = 16'hFFFE;
    localparam logic [15:0] P8_1 = 16'h0012;
    localparam logic [15:0] P8_2 = 16'h00BF;
    localparam logic [15:0] P8_3 = 16'h00FD;
    localparam logic [15:0] P5_1 = 16'h0012;
    localparam logic [15:0] PRE_ZERO = 16'h0000;
    typedef enum logic [1:0] {CRC_IDLE, CRC_DATA, CRC_APPEND} crc_state_e;
endpackage : txdrv_pkg

// ===== verilog/tx_driver_crc_control.sv
`timescale 1ns/100ps
// Operation
// - Bit 7 inverts the second RF output.
// - Bit 6 inverts the first RF output.
// - Enable bit drives both outputs together.
// - Style field picks drive; three codes unsupported.
// - Amplitude field picks one of four reductions.
// - Maximum carrier bit overrides amplitude reduction.
// - Residual carrier field sets modulation residual level.
// - Upper control nibble sets extra overshoot length.
// - Modulation invert bit inverts chosen source.
// - Source field: none, envelope, serial, reserved.
// - Upper load nibble feeds first overshoot stage.
// - Lower load nibble is trimmed load current.
// - CRC type selects CRC5, CRC8 or CRC16.
// - CRC invert bit inverts appended CRC.
// - CRC enable bit appends CRC to frame.
// - Preset field selects tabled CRC start value.
// - Code six loads user value, seven all ones; others undefined.
module tx_driver_crc_control
    import txdrv_pkg::*;
(
    input wire logic pclk, // Bus and block clock, 10 MHz.
    input wire logic presetn, // Asynchronous active-low reset.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic external_serial_input, // Asynchronous serial modulation pin.
    input wire logic [15:0] user_crc_preset, // Stored user CRC start value.
    input wire logic frame_start, // Pulse: a new frame begins.
    input wire logic data_valid, // A data bit is offered.
    input wire logic data_bit, // The offered data bit.
    input wire logic data_last, // The offered bit is the last of the frame.
    output logic data_ready, // Low while the CRC is being appended.
    output logic out_valid, // A frame bit is on out_bit.
    output logic out_bit, // Outgoing frame bit, data then CRC.
    output logic out_is_crc, // The outgoing bit belongs to the CRC.
    output logic first_rf_output_o, // First RF output level.
    output logic first_rf_output_oe_n, // First RF output enable, low drives.
    output logic second_rf_output_o, // Second RF output level.
    output logic second_rf_output_oe_n, // Second RF output enable, low drives.
    output logic [10:0] carrier_amplitude_reduction, // Millivolts below the supply.
    output logic carrier_max, // Carrier at maximum amplitude.
    output logic [4:0] residual_carrier, // Residual carrier setting.
    output logic [3:0] overshoot_extra_length, // Extra modulation, carrier clocks.
    output logic [3:0] overshoot_first_stage, // First overshoot stage value.
    output logic [3:0] expected_load_current_trim // Trimmed expected load current.
);

    logic [7:0] drive_mode_r; // Output inversion, enable and style.
    logic [7:0] amp_r; // Amplitude and residual carrier.
    logic [7:0] transmit_control_r; // Overshoot, max carrier, modulation select.
    logic [7:0] load_r; // Overshoot stage and load trim.
    logic [7:0] crccfg_r; // CRC preset, type, invert, enable.
    logic [31:0] prdata_r; // Read data captured in the setup cycle.
    logic [7:0] idx; // Word index of the current address.
    logic hit; // Address maps to a register.
    logic wr_en; // Write takes effect this edge.
    logic sig_meta_r; // First synchroniser stage.
    logic sig_sync_r; // Second synchroniser stage.
    logic mod_sig; // Selected, inverted modulation signal.
    logic envelope; // Internal transmit envelope.
    logic [2:0] style; // Output drive style field.
    crc_state_e state_r; // CRC sequencer state.
    logic [15:0] crc_r; // CRC shift register.
    logic [4:0] cnt_r; // Remaining CRC bits to send.
    logic [15:0] crc_nxt; // CRC after the offered bit.
    logic [15:0] poly; // Reflected polynomial for the type.
    logic [4:0] width; // CRC width for the type.
    logic [15:0] preset; // Start value for the type and code.
    logic take; // A data bit is accepted.

    assign idx = paddr[9:2];
    assign hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                 (idx >= IDX_DRIVE_MODE) && (idx <= IDX_CRC_CONFIG);
    assign wr_en = psel && penable && pwrite && hit;
    // No wait state: read data is captured in setup and shown in access.
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_r;

    // Register writes; reserved bits are masked so they read as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_mode_r <= RST_REG;
            amp_r <= RST_REG;
            transmit_control_r <= RST_REG;
            load_r <= RST_REG;
            crccfg_r <= RST_REG;
        end else if (wr_en) begin
            unique case (idx)
                IDX_DRIVE_MODE: drive_mode_r <= pwdata[7:0] & MASK_DRIVE_MODE;
                IDX_CARRIER_AMP: amp_r <= pwdata[7:0] & MASK_CARRIER_AMP;
                IDX_TX_CONTROL: transmit_control_r <= pwdata[7:0];
                IDX_LOAD_OVERSHOOT: load_r <= pwdata[7:0];
                default: crccfg_r <= pwdata[7:0] & MASK_CRC_CONFIG;
            endcase
        end
    end

    // Read data is fetched one cycle early so the bus sees a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (psel && !penable && !pwrite && hit) begin
            unique case (idx)
                IDX_DRIVE_MODE: prdata_r <= {24'h0, drive_mode_r};
                IDX_CARRIER_AMP: prdata_r <= {24'h0, amp_r};
                IDX_TX_CONTROL: prdata_r <= {24'h0, transmit_control_r};
                IDX_LOAD_OVERSHOOT: prdata_r <= {24'h0, load_r};
                default: prdata_r <= {24'h0, crccfg_r};
            endcase
        end else if (psel && !penable) begin
            // Unmapped or write: nothing useful to return.
            prdata_r <= 32'h0;
        end
    end

    // The serial pin is asynchronous, so it passes two flops first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_meta_r <= 1'b0;
            sig_sync_r <= 1'b0;
        end else begin
            sig_meta_r <= external_serial_input;
            sig_sync_r <= sig_meta_r;
        end
    end

    // The envelope idles high and follows the outgoing frame bits.
    assign envelope = out_valid ? out_bit : 1'b1;

    // Modulation source select; the reserved code gives no modulation.
    always_comb begin
        unique case (transmit_control_r[1:0])
            MOD_ENVELOPE: mod_sig = envelope;
            MOD_SERIAL: mod_sig = sig_sync_r;
            default: mod_sig = 1'b0;
        endcase
        mod_sig = mod_sig ^ transmit_control_r[B_MODINV];
    end

    assign style = drive_mode_r[2:0];

    // RF outputs. Unsupported style codes fall back to high impedance,
    // which is the safest thing to present to an antenna.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_rf_output_o <= 1'b0;
            second_rf_output_o <= 1'b0;
            first_rf_output_oe_n <= 1'b1;
            second_rf_output_oe_n <= 1'b1;
        end else if (!drive_mode_r[B_TRANSMITTER_OUTPUTS_ENABLE]) begin
            // Both outputs stay released while the transmitter is off.
            first_rf_output_o <= 1'b0;
            second_rf_output_o <= 1'b0;
            first_rf_output_oe_n <= 1'b1;
            second_rf_output_oe_n <= 1'b1;
        end else begin
            unique case (style)
                STYLE_PUSH_PULL: begin
                    first_rf_output_o <= mod_sig ^ drive_mode_r[B_INV1];
                    second_rf_output_o <= mod_sig ^ drive_mode_r[B_INV2];
                    first_rf_output_oe_n <= 1'b0;
                    second_rf_output_oe_n <= 1'b0;
                end
                STYLE_OPEN_DRAIN: begin
                    // Only a low level is driven; a high releases the pin.
                    first_rf_output_o <= 1'b0;
                    second_rf_output_o <= 1'b0;
                    first_rf_output_oe_n <= mod_sig ^ drive_mode_r[B_INV1];
                    second_rf_output_oe_n <= mod_sig ^ drive_mode_r[B_INV2];
                end
                STYLE_FIX_LOW, STYLE_FIX_HIGH: begin
                    first_rf_output_o <= (style == STYLE_FIX_HIGH);
                    second_rf_output_o <= (style == STYLE_FIX_HIGH);
                    first_rf_output_oe_n <= 1'b0;
                    second_rf_output_oe_n <= 1'b0;
                end
                default: begin
                    first_rf_output_o <= 1'b0;
                    second_rf_output_o <= 1'b0;
                    first_rf_output_oe_n <= 1'b1;
                    second_rf_output_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Carrier amplitude settings handed to the analog driver.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_amplitude_reduction <= CW_RED_NONE;
            carrier_max <= 1'b0;
            residual_carrier <= 5'h00;
            overshoot_extra_length <= 4'h0;
            overshoot_first_stage <= 4'h0;
            expected_load_current_trim <= 4'h0;
        end else begin
            carrier_max <= transmit_control_r[B_CWMAX];
            if (transmit_control_r[B_CWMAX]) begin
                carrier_amplitude_reduction <= CW_RED_NONE;
            end else begin
                unique case (amp_r[7:6])
                    2'h0: carrier_amplitude_reduction <= CW_RED_0;
                    2'h1: carrier_amplitude_reduction <= CW_RED_1;
                    2'h2: carrier_amplitude_reduction <= CW_RED_2;
                    2'h3: carrier_amplitude_reduction <= CW_RED_3;
                endcase
            end
            residual_carrier <= amp_r[4:0];
            overshoot_extra_length <= transmit_control_r[7:4];
            overshoot_first_stage <= load_r[7:4];
            expected_load_current_trim <= load_r[3:0];
        end
    end

    // Polynomial, width and start value for the configured CRC type.
    always_comb begin
        poly = POLY16;
        width = CRC_W16;
        unique case (crccfg_r[3:2])
            CRC_T5: begin
                poly = POLY5;
                width = CRC_W5;
            end
            CRC_T8: begin
                poly = POLY8;
                width = CRC_W8;
            end
            default: begin
                poly = POLY16;
                width = CRC_W16;
            end
        endcase
        // Undefined preset codes start from zero.
        preset = PRE_ZERO;
        unique case (crccfg_r[6:4])
            PRE_C1: preset = (crccfg_r[3:2] == CRC_T16) ? P16_1 : (crccfg_r[3:2] == CRC_T8) ? P8_1 : P5_1;
            PRE_C2: preset = (crccfg_r[3:2] == CRC_T16) ? P16_2 : (crccfg_r[3:2] == CRC_T8) ? P8_2 : PRE_ZERO;
            PRE_C3: preset = (crccfg_r[3:2] == CRC_T16) ? P16_3 : (crccfg_r[3:2] == CRC_T8) ? P8_3 : PRE_ZERO;
            PRE_USER: preset = user_crc_preset;
            PRE_C7: preset = MASK16;
            default: preset = PRE_ZERO;
        endcase
        preset = preset & ((width == CRC_W5) ? MASK5 : (width == CRC_W8) ? MASK8 : MASK16);
        // Reflected shift: data go in LSB first, as they leave the block.
        crc_nxt = {1'b0, crc_r[15:1]} ^ ((crc_r[0] ^ data_bit) ? poly : PRE_ZERO);
    end

    assign data_ready = (state_r != CRC_APPEND);
    assign take = data_valid && data_ready;

    // Frame sequencer: data bits pass through, the CRC follows the last one.
    // The reserved CRC type appends nothing rather than guessing a width.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= CRC_IDLE;
            crc_r <= PRE_ZERO;
            cnt_r <= 5'h00;
        end else if (frame_start && state_r != CRC_APPEND) begin
            state_r <= CRC_DATA;
            crc_r <= preset;
        end else begin
            unique case (state_r)
                CRC_IDLE: begin
                    cnt_r <= 5'h00;
                end
                CRC_DATA: begin
                    if (take) begin
                        crc_r <= crc_nxt;
                        if (data_last && crccfg_r[B_CRCEN] && crccfg_r[3:2] != 2'h3) begin
                            state_r <= CRC_APPEND;
                            cnt_r <= width;
                        end else if (data_last) begin
                            state_r <= CRC_IDLE;
                        end
                    end
                end
                CRC_APPEND: begin
                    crc_r <= {1'b0, crc_r[15:1]};
                    cnt_r <= cnt_r - 5'h01;
                    if (cnt_r == 5'h01) begin
                        state_r <= CRC_IDLE;
                    end
                end
            endcase
        end
    end

    // Outgoing bit stream; the CRC starts in the cycle after the last bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_bit <= 1'b0;
            out_is_crc <= 1'b0;
        end else if (state_r == CRC_APPEND) begin
            out_valid <= 1'b1;
            out_bit <= crc_r[0] ^ crccfg_r[B_CRCINV];
            out_is_crc <= 1'b1;
        end else begin
            out_valid <= take && (state_r == CRC_DATA);
            out_bit <= data_bit;
            out_is_crc <= 1'b0;
        end
    end

    sequence s_last_taken;
        take && data_last && state_r == CRC_DATA;
    endsequence

    sequence s_append_start;
        state_r == CRC_APPEND && !data_ready;
    endsequence

    chk_tx_disable_off: assert property (@(posedge pclk) disable iff (!presetn)
        !drive_mode_r[B_TRANSMITTER_OUTPUTS_ENABLE] |=> first_rf_output_oe_n && second_rf_output_oe_n)
        else $error("RF outputs driven while transmitter disabled");

    chk_second_out_inv: assert property (@(posedge pclk) disable iff (!presetn)
        drive_mode_r[B_TRANSMITTER_OUTPUTS_ENABLE] && style == STYLE_PUSH_PULL
        |=> second_rf_output_o == ($past(mod_sig) ^ $past(drive_mode_r[B_INV2])))
        else $error("Second RF output inversion wrong");

    chk_first_out_inv: assert property (@(posedge pclk) disable iff (!presetn)
        drive_mode_r[B_TRANSMITTER_OUTPUTS_ENABLE] && style == STYLE_PUSH_PULL
        |=> first_rf_output_o == ($past(mod_sig) ^ $past(drive_mode_r[B_INV1])))
        else $error("First RF output inversion wrong");

    // A fixed-level style drives both pins from the style code alone, ignoring modulation.
    chk_fixed_level: assert property (@(posedge pclk) disable iff (!presetn)
        drive_mode_r[B_TRANSMITTER_OUTPUTS_ENABLE] && style == STYLE_FIX_HIGH
        |=> first_rf_output_o && second_rf_output_o && !first_rf_output_oe_n && !second_rf_output_oe_n)
        else $error("Fixed high level not driven");

    chk_cw_max_over: assert property (@(posedge pclk) disable iff (!presetn)
        transmit_control_r[B_CWMAX] |=> carrier_amplitude_reduction == CW_RED_NONE && carrier_max)
        else $error("Maximum carrier did not override reduction");

    chk_mod_none_src: assert property (@(posedge pclk) disable iff (!presetn)
        transmit_control_r[1:0] == MOD_NONE |-> mod_sig == transmit_control_r[B_MODINV])
        else $error("No-modulation source not constant");

    chk_crc_append_len: assert property (@(posedge pclk) disable iff (!presetn)
        s_last_taken ##0 (crccfg_r[B_CRCEN] && crccfg_r[3:2] == CRC_T8)
        |=> s_append_start [*8] ##1 data_ready)
        else $error("CRC8 append length wrong");

    chk_crc_no_append: assert property (@(posedge pclk) disable iff (!presetn)
        s_last_taken ##0 !crccfg_r[B_CRCEN] |=> ##1 !out_is_crc)
        else $error("CRC appended while disabled");

    chk_crc_first_bit: assert property (@(posedge pclk) disable iff (!presetn)
        s_last_taken ##0 crccfg_r[B_CRCEN] && crccfg_r[3:2] != 2'h3
        |=> ##1 out_is_crc && out_bit == ($past(crc_r[0]) ^ crccfg_r[B_CRCINV]))
        else $error("First CRC bit not inverted as configured");

    chk_preset_ffff: assert property (@(posedge pclk) disable iff (!presetn)
        frame_start && state_r != CRC_APPEND && crccfg_r[6:4] == PRE_C7 && crccfg_r[3:2] == CRC_T16
        |=> crc_r == MASK16)
        else $error("CRC16 preset code seven not loaded");

    chk_write_mode: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && idx == IDX_DRIVE_MODE |=> drive_mode_r == ($past(pwdata[7:0]) & MASK_DRIVE_MODE))
        else $error("Drive mode register write lost");

endmodule : tx_driver_crc_control

// ===== verification/antenna_model.sv
`timescale 1ns/100ps
// Matching network seen from the two RF pins; a weak pull-up holds a released pin high.
module antenna_model (
    input wire logic first_o, // First driver level.
    input wire logic first_oe_n, // First driver enable, low drives.
    input wire logic second_o, // Second driver level.
    input wire logic second_oe_n, // Second driver enable, low drives.
    output logic first_pin, // Level seen on the first pin.
    output logic second_pin // Level seen on the second pin.
);
    // A released pin goes to the pull-up level, so a stale driven value can never pass for a match.
    assign first_pin = first_oe_n ? 1'b1 : first_o;
    assign second_pin = second_oe_n ? 1'b1 : second_o;
endmodule : antenna_model

// ===== verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import txdrv_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, ser = 1'b0, fs = 1'b0, dv = 1'b0, db = 1'b0, dl = 1'b0, drdy, ov, ob, oc;
    logic o1, oe1, o2, oe2, pin1, pin2, cmax;
    logic [10:0] red;
    logic [4:0] res;
    logic [3:0] ovx, ov1, ild;
    logic [15:0] got, upre = 16'h5A3C;
    logic [7:0] masks [5] = '{8'hCF, 8'hDF, 8'hFF, 8'hFF, 8'h7F};
    logic [10:0] reds [4] = '{11'h064, 11'h0FA, 11'h1F4, 11'h3E8};
    int failures = 0, checked = 0, ncrc = 0, ndat = 0, cyc = 0, i;
    always #50 pclk = ~pclk;
    tx_driver_crc_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_serial_input(ser), .user_crc_preset(upre), .frame_start(fs),
        .data_valid(dv), .data_bit(db), .data_last(dl), .data_ready(drdy), .out_valid(ov),
        .out_bit(ob), .out_is_crc(oc), .first_rf_output_o(o1), .first_rf_output_oe_n(oe1),
        .second_rf_output_o(o2), .second_rf_output_oe_n(oe2), .carrier_amplitude_reduction(red),
        .carrier_max(cmax), .residual_carrier(res), .overshoot_extra_length(ovx),
        .overshoot_first_stage(ov1), .expected_load_current_trim(ild));
    antenna_model ant_u (.first_o(o1), .first_oe_n(oe1), .second_o(o2), .second_oe_n(oe2),
        .first_pin(pin1), .second_pin(pin2));
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Compares one observed value with its expectation.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask : check
    // One APB transfer to register index idx; a hang is caught by the cycle ceiling.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Sends one byte LSB first and compares the appended CRC with a bit-serial reference.
    task automatic frame(input logic [1:0] t, input logic [2:0] pc, input logic inv, input logic en);
        logic [15:0] c, p, m;
        logic fb;
        int w, k, n;
        w = (t == 2'h2) ? 16 : (t == 2'h1) ? 8 : 5;
        m = 16'hFFFF >> (16 - w);
        p = (t == 2'h2) ? 16'h8408 : (t == 2'h1) ? 16'h00B8 : 16'h0012;
        c = (pc == 3'h1) ? ((t == 2'h2) ? 16'h6363 : 16'h0012) : (pc == 3'h7) ? 16'hFFFF : upre;
        c = c & m;
        apb(1'b1, {2'b00, IDX_CRC_CONFIG}, {1'b0, pc, t, inv, en});
        ncrc = 0;
        ndat = 0;
        got = 16'h0000;
        fs <= 1'b1;
        @(posedge pclk);
        fs <= 1'b0;
        for (k = 0; k < 8; k++) begin
            dv <= 1'b1;
            db <= k[0] ^ k[2];
            dl <= (k == 7);
            fb = c[0] ^ k[0] ^ k[2];
            c = (c >> 1) ^ (fb ? p : 16'h0000);
            @(posedge pclk);
        end
        dv <= 1'b0;
        dl <= 1'b0;
        @(negedge pclk);
        check("ready in append", drdy, !en);
        n = 0;
        while (ncrc < w && n < 40) begin
            @(posedge pclk);
            n++;
        end
        repeat (3) @(posedge pclk);
        check("data bits", ndat, 8);
        check("ready after frame", drdy, 1'b1);
        check("crc bits", ncrc, en ? w : 0);
        if (en) check("crc value", got, c ^ (inv ? m : 16'h0000));
    endtask : frame
    // Collects the outgoing stream and cuts a hang short.
    always @(posedge pclk) begin
        cyc++;
        if (ov === 1'b1 && oc === 1'b1) begin
            got[ncrc] = ob;
            ncrc++;
        end else if (ov === 1'b1) ndat++;
        if (cyc == 8000) begin
            failures++;
            give_verdict();
        end
    end
    // Main sequence: reset, registers, carrier fields, RF drive, CRC frames.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("oe after reset", oe1, 1'b1);
        for (i = 0; i < 5; i++) begin
            apb(1'b0, 10'h028 + i, 8'h00);
            check("reset value", rd, 32'h0);
            apb(1'b1, 10'h028 + i, 8'hFF);
            apb(1'b0, 10'h028 + i, 8'h00);
            check("writable bits", rd, {24'h0, masks[i]});
        end
        apb(1'b0, 10'h02D, 8'h00);
        check("unmapped error", err, 1'b1);
        repeat (3) @(posedge pclk);
        check("max carrier", {cmax, red}, 12'h800);
        check("fields", {res, ovx, ov1, ild}, 17'h1FFFF);
        $display("registers test done");
        apb(1'b1, {2'b00, IDX_TX_CONTROL}, 8'h00);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, {2'b00, IDX_CARRIER_AMP}, {i[1:0], 6'h0A});
            repeat (3) @(posedge pclk);
            check("reduction", red, reds[i]);
            check("residual", res, 5'h0A);
        end
        $display("carrier test done");
        for (i = 0; i < 16; i++) begin
            apb(1'b1, {2'b00, IDX_DRIVE_MODE}, {i[3], i[2], 2'b00, 1'b1, STYLE_PUSH_PULL});
            apb(1'b1, {2'b00, IDX_TX_CONTROL}, {5'h00, i[1], MOD_SERIAL});
            ser <= i[0];
            repeat (5) @(posedge pclk);
            check("first pin", pin1, i[0] ^ i[1] ^ i[2]);
            check("second pin", pin2, i[0] ^ i[1] ^ i[3]);
            check("enables", {oe1, oe2}, 2'b00);
        end
        apb(1'b1, {2'b00, IDX_TX_CONTROL}, {6'h00, MOD_NONE});
        repeat (5) @(posedge pclk);
        ser <= ~ser;
        repeat (5) @(posedge pclk);
        check("no modulation", {o1, o2}, 2'b11);
        apb(1'b1, {2'b00, IDX_TX_CONTROL}, {6'h00, MOD_ENVELOPE});
        repeat (3) @(posedge pclk);
        check("idle envelope", {o1, o2}, 2'b00);
        apb(1'b1, {2'b00, IDX_DRIVE_MODE}, {4'h0, 1'b1, STYLE_OPEN_DRAIN});
        apb(1'b1, {2'b00, IDX_TX_CONTROL}, {6'h00, MOD_SERIAL});
        for (i = 0; i < 2; i++) begin
            ser <= i[0];
            repeat (5) @(posedge pclk);
            check("open drain pin", pin1, i[0]);
        end
        apb(1'b1, {2'b00, IDX_DRIVE_MODE}, {4'h0, 1'b1, STYLE_FIX_HIGH});
        repeat (3) @(posedge pclk);
        check("fixed high", {o1, oe1, o2, oe2}, 4'hA);
        apb(1'b1, {2'b00, IDX_DRIVE_MODE}, {4'h0, 1'b1, STYLE_FIX_LOW});
        repeat (3) @(posedge pclk);
        check("fixed low", {o1, oe1, o2, oe2}, 4'h0);
        apb(1'b1, {2'b00, IDX_DRIVE_MODE}, {4'h0, 1'b1, STYLE_HIGH_Z});
        repeat (3) @(posedge pclk);
        check("high impedance", {oe1, oe2, pin1, pin2}, 4'hF);
        apb(1'b1, {2'b00, IDX_DRIVE_MODE}, {4'h0, 1'b0, STYLE_PUSH_PULL});
        repeat (3) @(posedge pclk);
        check("disabled", {oe1, oe2}, 2'b11);
        $display("rf drive test done");
        for (i = 0; i < 3; i++) frame(i[1:0], 3'h1, 1'b0, 1'b1);
        frame(CRC_T16, 3'h7, 1'b1, 1'b1);
        frame(CRC_T8, 3'h6, 1'b0, 1'b1);
        frame(CRC_T5, 3'h7, 1'b1, 1'b1);
        frame(CRC_T16, 3'h1, 1'b0, 1'b0);
        $display("crc test done");
        give_verdict();
    end
endmodule : tb_top
